// ---- irq_vector_ctrl.sv ----
// Maskable and non-maskable interrupt vectoring with saved PC handling
`timescale 1ns/1ps
module irq_vector_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [irq_vec_pkg::NUM_SRC-1:0] src_req,
	input wire logic [irq_vec_pkg::NUM_EXT-1:0] ext_edge_pin,
	input wire logic [irq_vec_pkg::NUM_SRC-1:0] src_mask,
	input wire logic [irq_vec_pkg::NUM_SRC*irq_vec_pkg::LEVEL_W-1:0] src_level,
	input wire logic nmi_pin,
	input wire logic watchdog1_nonmask_req,
	input wire logic watchdog2_nonmask_req,
	input wire logic nonmask_active_flag,
	input wire logic irq_disable_flag,
	input wire logic [irq_vec_pkg::ADDR_W-1:0] following_instr_addr,
	input wire logic [irq_vec_pkg::ADDR_W-1:0] current_instr_addr,
	input wire logic instr_abandonable,
	input wire logic mask_ack,
	input wire logic mask_return,
	input wire logic nmi_ack,
	input wire logic illegal_opcode_trap,
	output logic mask_req,
	output logic [irq_vec_pkg::CODE_W-1:0] mask_code,
	output logic [irq_vec_pkg::ADDR_W-1:0] mask_handler,
	output logic [irq_vec_pkg::LEVEL_W-1:0] mask_level,
	output logic [5:0] mask_default_prio,
	output logic nmi_req,
	output logic [irq_vec_pkg::CODE_W-1:0] nmi_code,
	output logic [irq_vec_pkg::ADDR_W-1:0] nmi_handler,
	output logic [irq_vec_pkg::ADDR_W-1:0] maskable_saved_pc,
	output logic [irq_vec_pkg::ADDR_W-1:0] fatal_saved_pc,
	output logic [irq_vec_pkg::ADDR_W-1:0] debug_saved_pc,
	output logic [irq_vec_pkg::ADDR_W-1:0] illegal_instr_addr,
	output logic [irq_vec_pkg::NUM_SRC-1:0] pending_status
);
	localparam int N = irq_vec_pkg::NUM_SRC;
	localparam int LW = irq_vec_pkg::LEVEL_W;
	localparam int IW = irq_vec_pkg::IDX_W;
	localparam int NE = irq_vec_pkg::NUM_EXT;
	localparam int NN = irq_vec_pkg::NUM_NMI;

	typedef enum logic [1:0] {
		NMI_SEL_PIN,
		NMI_SEL_WDT1,
		NMI_SEL_WDT2
	} nmi_sel_t;

	logic rst_meta_reg;
	logic rst_sync_reg;
	logic [NE-1:0] ext_meta_reg;
	logic [NE-1:0] ext_sync_reg;
	logic [NE-1:0] ext_prev_reg;
	logic [NE-1:0] ext_rise;
	logic nmi_meta_reg;
	logic nmi_sync_reg;
	logic nmi_prev_reg;
	logic nmi_rise;
	logic [N-1:0] pend_reg;
	logic [N-1:0] pend_next;
	logic [N-1:0] pend_set;
	logic [N-1:0] eligible;
	logic [NN-1:0] nmi_pend_reg;
	logic [NN-1:0] nmi_pend_next;
	logic [NN-1:0] nmi_set;
	logic [NN-1:0] nmi_elig;
	logic [7:0] in_service_reg;
	logic [7:0] in_service_next;
	logic [3:0] ceiling;
	logic res_any;
	logic [IW-1:0] res_idx;
	logic [LW-1:0] res_level;
	logic [IW-1:0] grant_idx_reg;
	nmi_sel_t nmi_sel_reg;
	nmi_sel_t nmi_pick;
	logic mask_take;
	logic nmi_take;
	logic [irq_vec_pkg::ADDR_W-1:0] restored_pc;

	// Reset release through two flops; assertion stays asynchronous
	// Not gated by ce, so the block always leaves reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Pin synchronisers; edge detection reads the second and third stages, never the first
	// Frozen by ce too; an edge seen during a freeze lands afterwards
	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			ext_meta_reg <= '0;
			ext_sync_reg <= '0;
			ext_prev_reg <= '0;
			nmi_meta_reg <= 1'b0;
			nmi_sync_reg <= 1'b0;
			nmi_prev_reg <= 1'b0;
		end else if (ce) begin
			ext_meta_reg <= ext_edge_pin;
			ext_sync_reg <= ext_meta_reg;
			ext_prev_reg <= ext_sync_reg;
			nmi_meta_reg <= nmi_pin;
			nmi_sync_reg <= nmi_meta_reg;
			nmi_prev_reg <= nmi_sync_reg;
		end
	end

	// One detector per pin; idle level after reset is low, so no false edge
	for (genvar g = 0; g < NE; g++) begin : g_pin_edge
		assign ext_rise[g] = ext_sync_reg[g] && !ext_prev_reg[g];
	end
	assign nmi_rise = nmi_sync_reg && !nmi_prev_reg;

	// Rising edge is the valid edge; pins land in their table slots
	// Pin slots also take src_req; both OR into pending
	always_comb begin
		pend_set = src_req;
		for (int e = 0; e < NE; e++) begin
			if (ext_rise[e]) begin
				pend_set[irq_vec_pkg::EXT_SLOT[e]] = 1'b1;
			end
		end
	end

	// Highest (smallest) in-service level bounds what may nest
	// One in-service bit per programmable level
	always_comb begin
		ceiling = irq_vec_pkg::NO_CEILING;
		for (int l = 7; l >= 0; l--) begin
			if (in_service_reg[l]) begin
				ceiling = 4'(l);
			end
		end
	end

	// Same level cannot nest, only strictly higher (smaller) levels
	// Mask hides a request from the resolver but never clears it
	always_comb begin
		for (int i = 0; i < N; i++) begin
			eligible[i] = pend_reg[i] && !src_mask[i]
				&& ({1'b0, src_level[i*LW +: LW]} < ceiling);
		end
	end

	// Purely combinational over all slots; the result is registered below
	prio_resolver #(
		.N(N),
		.LW(LW),
		.IW(IW)
	) u_resolver (
		.req(eligible),
		.level(src_level),
		.any(res_any),
		.idx(res_idx),
		.win_level(res_level)
	);

	// An ack without a standing offer is ignored
	assign mask_take = mask_ack && mask_req;
	assign nmi_take = nmi_ack && nmi_req;

	// Set wins over the clear of the granted slot
	always_comb begin
		pend_next = pend_reg;
		if (mask_take) begin
			pend_next[grant_idx_reg] = 1'b0;
		end
		pend_next = pend_next | pend_set;
	end

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			pend_reg <= '0;
		end else if (ce) begin
			pend_reg <= pend_next;
		end
	end

	assign pending_status = pend_reg;

	// Level bookkeeping for nesting; return retires the highest in service
	// A take and a return in one cycle both apply, so neither is lost
	always_comb begin
		in_service_next = in_service_reg;
		if (mask_return && ceiling != irq_vec_pkg::NO_CEILING) begin
			in_service_next[ceiling[2:0]] = 1'b0;
		end
		if (mask_take) begin
			in_service_next[mask_level] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			in_service_reg <= '0;
		end else if (ce) begin
			in_service_reg <= in_service_next;
		end
	end

	// Maskable presentation; blocked while flags are set or a nonmask waits
	// Code and level register with the request, so an ack sees a matching set
	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			mask_req <= 1'b0;
			grant_idx_reg <= '0;
			mask_code <= irq_vec_pkg::CODE_RESET;
			mask_handler <= irq_vec_pkg::PC_RESET;
			mask_level <= '0;
			mask_default_prio <= '0;
		end else if (ce) begin
			// Drop for one cycle after a take so the cleared slot is not re-offered
			mask_req <= res_any && !nonmask_active_flag && !irq_disable_flag
				&& !(|nmi_elig) && !mask_take;
			grant_idx_reg <= res_idx;
			mask_code <= irq_vec_pkg::SRC_CODE[res_idx];
			// Code table covers every slot
			// Later slots likewise
			mask_handler <= irq_vec_pkg::handler_of(irq_vec_pkg::SRC_CODE[res_idx]);
			mask_level <= res_level;
			mask_default_prio <= irq_vec_pkg::SRC_PRIO[res_idx];
		end
	end

	// Nonmask sources: pin edge and the two watchdog pulses
	always_comb begin
		nmi_set = '0;
		nmi_set[irq_vec_pkg::NMI_PIN] = nmi_rise;
		nmi_set[irq_vec_pkg::NMI_WDT1] = watchdog1_nonmask_req;
		nmi_set[irq_vec_pkg::NMI_WDT2] = watchdog2_nonmask_req;
	end

	// Watchdog2 ignores the active flag; the others wait for it to clear
	always_comb begin
		nmi_elig = nmi_pend_reg;
		if (nonmask_active_flag) begin
			nmi_elig[irq_vec_pkg::NMI_PIN] = 1'b0;
			nmi_elig[irq_vec_pkg::NMI_WDT1] = 1'b0;
		end
	end

	always_comb begin
		if (nmi_elig[irq_vec_pkg::NMI_WDT2]) begin
			nmi_pick = NMI_SEL_WDT2;
		end else if (nmi_elig[irq_vec_pkg::NMI_WDT1]) begin
			nmi_pick = NMI_SEL_WDT1;
		end else begin
			nmi_pick = NMI_SEL_PIN;
		end
	end

	// Only the taken source clears; losers stay pending, and set wins
	always_comb begin
		nmi_pend_next = nmi_pend_reg;
		if (nmi_take) begin
			nmi_pend_next[nmi_sel_reg] = 1'b0;
		end
		nmi_pend_next = nmi_pend_next | nmi_set;
	end

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			nmi_pend_reg <= '0;
		end else if (ce) begin
			nmi_pend_reg <= nmi_pend_next;
		end
	end

	// Offer drops for a cycle after a take, as on the maskable side
	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			nmi_req <= 1'b0;
			nmi_sel_reg <= NMI_SEL_PIN;
			nmi_code <= irq_vec_pkg::CODE_RESET;
			nmi_handler <= irq_vec_pkg::PC_RESET;
		end else if (ce) begin
			nmi_req <= (|nmi_elig) && !nmi_take;
			nmi_sel_reg <= nmi_pick;
			nmi_code <= irq_vec_pkg::NMI_CODE[nmi_pick];
			nmi_handler <= irq_vec_pkg::handler_of(irq_vec_pkg::NMI_CODE[nmi_pick]);
		end
	end

	// Abandoned instruction restarts after service, so save its own address
	// Illegal opcode traps bypass this path and keep the following address
	assign restored_pc = instr_abandonable ? current_instr_addr
		: following_instr_addr;

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			maskable_saved_pc <= irq_vec_pkg::PC_RESET;
			fatal_saved_pc <= irq_vec_pkg::PC_RESET;
		end else if (ce) begin
			if (mask_take) begin
				maskable_saved_pc <= restored_pc;
			end
			if (nmi_take) begin
				fatal_saved_pc <= restored_pc;
			end
		end
	end

	// Illegal opcode saves the following address; offender sits one word back
	// Trap comes from the core on this clock, so it needs no synchroniser
	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			debug_saved_pc <= irq_vec_pkg::PC_RESET;
			illegal_instr_addr <= irq_vec_pkg::PC_RESET;
		end else if (ce) begin
			if (illegal_opcode_trap) begin
				debug_saved_pc <= following_instr_addr;
				illegal_instr_addr <= following_instr_addr - irq_vec_pkg::ILLEGAL_OPCODE_TRAP_BACKSTEP;
			end
		end
	end

endmodule : irq_vector_ctrl

// ---- irq_vec_pkg.sv ----
// Shared constants for the maskable and non-maskable interrupt vector and priority block
package irq_vec_pkg;

	localparam int NUM_SRC = 39;
	localparam int LEVEL_W = 3;
	localparam int IDX_W = 6;
	localparam int CODE_W = 16;
	localparam int ADDR_W = 32;
	localparam int NUM_EXT = 4;
	localparam int NUM_NMI = 3;

	// Source slot of each external edge pin, in pin order 4, 5, 6, 7
	localparam int EXT_SLOT [0:NUM_EXT-1] = '{0, 1, 2, 34};

	// Exception code per slot; slot order is default priority order
	localparam logic [CODE_W-1:0] SRC_CODE [0:NUM_SRC-1] = '{
		16'h00d0, 16'h00e0, 16'h00f0, 16'h0100, 16'h0110, 16'h0120, 16'h0130,
		16'h0140, 16'h0150, 16'h0160, 16'h0170, 16'h0180, 16'h0190, 16'h01a0,
		16'h01b0, 16'h01c0, 16'h01d0, 16'h01e0, 16'h01f0, 16'h0200, 16'h0210,
		16'h0220, 16'h0230, 16'h0240, 16'h0250, 16'h0260, 16'h0270, 16'h0280,
		16'h0290, 16'h02a0, 16'h02b0, 16'h0310, 16'h0320, 16'h0330, 16'h0390,
		16'h03d0, 16'h03e0, 16'h03f0, 16'h0400
	};

	// Default priority number per slot, for reporting only
	localparam logic [5:0] SRC_PRIO [0:NUM_SRC-1] = '{
		6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e,
		6'h0f, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18,
		6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22,
		6'h23, 6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h30, 6'h31, 6'h32, 6'h33
	};

	// Non-maskable slots, index 0 is the pin
	localparam int NMI_PIN = 0;
	localparam int NMI_WDT1 = 1;
	localparam int NMI_WDT2 = 2;
	localparam logic [CODE_W-1:0] NMI_CODE [0:NUM_NMI-1] = '{16'h0010, 16'h0020, 16'h0030};

	localparam logic [ADDR_W-1:0] ILLEGAL_OPCODE_TRAP_BACKSTEP = 32'h0000_0004;
	localparam logic [ADDR_W-1:0] PC_RESET = 32'h0000_0000;
	localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
	localparam logic [3:0] NO_CEILING = 4'h8;

	function automatic logic [ADDR_W-1:0] handler_of(input logic [CODE_W-1:0] code);
		handler_of = {16'h0000, code};
	endfunction : handler_of

endpackage : irq_vec_pkg

// ---- prio_resolver.sv ----
// Level then default-order resolver for pending interrupt requests
`timescale 1ns/1ps
module prio_resolver #(
	parameter int N = 39,
	parameter int LW = 3,
	parameter int IW = 6
) (
	input wire logic [N-1:0] req,
	input wire logic [N*LW-1:0] level,
	output logic any,
	output logic [IW-1:0] idx,
	output logic [LW-1:0] win_level
);
	always_comb begin
		any = 1'b0;
		idx = '0;
		win_level = '0;
		// Strict less-than keeps the lowest slot among equal levels
		for (int i = 0; i < N; i++) begin
			if (req[i] && (!any || level[i*LW +: LW] < win_level)) begin
				any = 1'b1;
				idx = IW'(i);
				win_level = level[i*LW +: LW];
			end
		end
	end
endmodule : prio_resolver

// ---- irq_vector_ctrl_properties.sv ----
// Concurrent checks on the interrupt vector block ports
`timescale 1ns/1ps
module irq_vector_ctrl_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [irq_vec_pkg::NUM_SRC-1:0] src_req,
	input wire logic watchdog2_nonmask_req,
	input wire logic nonmask_active_flag,
	input wire logic irq_disable_flag,
	input wire logic [31:0] following_instr_addr,
	input wire logic [31:0] current_instr_addr,
	input wire logic instr_abandonable,
	input wire logic mask_ack,
	input wire logic nmi_ack,
	input wire logic illegal_opcode_trap,
	input wire logic mask_req,
	input wire logic [15:0] mask_code,
	input wire logic [31:0] mask_handler,
	input wire logic nmi_req,
	input wire logic [15:0] nmi_code,
	input wire logic [31:0] nmi_handler,
	input wire logic [31:0] maskable_saved_pc,
	input wire logic [31:0] fatal_saved_pc,
	input wire logic [31:0] debug_saved_pc,
	input wire logic [31:0] illegal_instr_addr,
	input wire logic [irq_vec_pkg::NUM_SRC-1:0] pending_status
);
	logic [31:0] resume_pc;
	assign resume_pc = instr_abandonable ? current_instr_addr : following_instr_addr;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence mask_take_s;
		mask_req && mask_ack && ce;
	endsequence
	sequence nmi_take_s;
		nmi_req && nmi_ack && ce;
	endsequence
	pend_set_a: assert property (ce && |src_req |=>
		(pending_status & $past(src_req)) == $past(src_req)) else $error("request not pending");
	take_drop_a: assert property (mask_take_s |=> !mask_req)
		else $error("offer stands after acceptance");
	mask_pc_a: assert property (mask_take_s |=> maskable_saved_pc == $past(resume_pc))
		else $error("maskable saved address wrong");
	mask_vec_a: assert property (mask_req |-> mask_handler == {16'h0000, mask_code})
		else $error("maskable handler differs from code");
	flag_block_a: assert property ((irq_disable_flag || nonmask_active_flag) [*2] |->
		!mask_req) else $error("maskable offered while flags set");
	wdt2_win_a: assert property (watchdog2_nonmask_req && ce |->
		##[1:3] (nmi_req && nmi_code == 16'h0030)) else $error("second watchdog not offered");
	nmi_vec_a: assert property (nmi_req |-> nmi_handler == {16'h0000, nmi_code} &&
		nmi_code inside {16'h0010, 16'h0020, 16'h0030}) else $error("nonmask vector wrong");
	illegal_pc_a: assert property (illegal_opcode_trap && ce |=>
		illegal_instr_addr == $past(following_instr_addr) - 32'h0000_0004 &&
		debug_saved_pc == $past(following_instr_addr)) else $error("trap address wrong");
	fatal_pc_a: assert property (nmi_take_s |=> fatal_saved_pc == $past(resume_pc))
		else $error("nonmask saved address wrong");
	ce_freeze_a: assert property (!ce |=> $stable(pending_status) && $stable(mask_req))
		else $error("state moved while clock enable low");
endmodule : irq_vector_ctrl_checker

bind irq_vector_ctrl irq_vector_ctrl_checker chk_u (.clk, .rst_n, .ce, .src_req,
	.watchdog2_nonmask_req, .nonmask_active_flag, .irq_disable_flag, .following_instr_addr,
	.current_instr_addr, .instr_abandonable, .mask_ack, .nmi_ack, .illegal_opcode_trap,
	.mask_req, .mask_code, .mask_handler, .nmi_req, .nmi_code, .nmi_handler,
	.maskable_saved_pc, .fatal_saved_pc, .debug_saved_pc, .illegal_instr_addr,
	.pending_status);

// ---- core_model.sv ----
// Behavioural core that accepts offered interrupt vectors
`timescale 1ns/1ps
module core_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic mask_req,
	input wire logic nmi_req,
	output logic mask_ack,
	output logic mask_return,
	output logic nmi_ack
);
	logic [1:0] wait_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_ack <= 1'b0;
			mask_return <= 1'b0;
			nmi_ack <= 1'b0;
			wait_reg <= 2'h0;
		end else begin
			// Handler returns at once; an ack the block ignored starts no handler
			mask_return <= mask_ack && mask_req;
			mask_ack <= 1'b0;
			nmi_ack <= nmi_req && !nmi_ack;
			// Slow mode lets the offer stand before acceptance
			if (mask_req && !mask_ack) begin
				if (!slow || wait_reg == 2'h3) begin
					mask_ack <= 1'b1;
					wait_reg <= 2'h0;
				end else begin
					wait_reg <= wait_reg + 2'h1;
				end
			end
		end
	end
endmodule : core_model

// ---- testbench.sv ----
// Randomised self-checking bench for the interrupt vector block
`timescale 1ns/1ps
module testbench;
	logic clk, rst_n, ce, nmi_pin, watchdog1_nonmask_req, watchdog2_nonmask_req, slow;
	logic nonmask_active_flag, irq_disable_flag, instr_abandonable, illegal_opcode_trap;
	logic mask_ack, mask_return, nmi_ack, mask_req, nmi_req;
	logic [irq_vec_pkg::NUM_SRC-1:0] src_req, src_mask, pending_status;
	logic [irq_vec_pkg::NUM_EXT-1:0] ext_edge_pin;
	logic [irq_vec_pkg::NUM_SRC*irq_vec_pkg::LEVEL_W-1:0] src_level;
	logic [31:0] following_instr_addr, current_instr_addr, mask_handler, nmi_handler;
	logic [31:0] maskable_saved_pc, fatal_saved_pc, debug_saved_pc, illegal_instr_addr;
	logic [15:0] mask_code, nmi_code;
	logic [2:0] mask_level;
	logic [5:0] mask_default_prio;
	logic [31:0] seed = 32'h1605;
	int mismatches = 0;
	int comparisons = 0;
	int a, b;
	irq_vector_ctrl dut_u (.clk, .rst_n, .ce, .src_req, .ext_edge_pin, .src_mask, .src_level,
		.nmi_pin, .watchdog1_nonmask_req, .watchdog2_nonmask_req, .nonmask_active_flag,
		.irq_disable_flag, .following_instr_addr, .current_instr_addr, .instr_abandonable,
		.mask_ack, .mask_return, .nmi_ack, .illegal_opcode_trap, .mask_req, .mask_code,
		.mask_handler, .mask_level, .mask_default_prio, .nmi_req, .nmi_code, .nmi_handler,
		.maskable_saved_pc, .fatal_saved_pc, .debug_saved_pc, .illegal_instr_addr,
		.pending_status);
	core_model core_u (.clk, .rst_n, .slow, .mask_req, .nmi_req, .mask_ack, .mask_return,
		.nmi_ack);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [5:0] exp_prio(input int s);
		exp_prio = 6'(s <= 30 ? s + 5 : s <= 33 ? s + 10 : s == 34 ? 44 : s + 13);
	endfunction : exp_prio
	// Codes step by 16 per priority, with a gap of five above priority 43
	function automatic logic [15:0] exp_code(input int s);
		exp_code = 16'h0080 + {6'h00, exp_prio(s), 4'h0} + (s >= 34 ? 16'h0050 : 16'h0000);
	endfunction : exp_code
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic rnd;
		seed = lfsr(seed);
		following_instr_addr = {seed[31:2], 2'b00};
		seed = lfsr(seed);
		current_instr_addr = {seed[29:0], 2'b00};
		instr_abandonable = seed[3];
		slow = seed[7];
	endtask : rnd
	// Bounded wait for acceptance; a hang counts as a mismatch
	task automatic take_mask(input int s);
		int n;
		logic [31:0] pc;
		n = 0;
		while (!(mask_req === 1'b1 && mask_ack === 1'b1) && n < 40) begin
			step(1);
			n++;
		end
		pc = instr_abandonable ? current_instr_addr : following_instr_addr;
		check({30'h0, mask_req, mask_ack}, 32'h3);
		check({16'h0000, mask_code}, {16'h0000, exp_code(s)});
		check(mask_handler, {16'h0000, exp_code(s)});
		check({26'h0, mask_default_prio}, {26'h0, exp_prio(s)});
		check({29'h0, mask_level}, {29'h0, src_level[s*3 +: 3]});
		step(1);
		check({31'h0, mask_req | pending_status[s]}, 32'h0);
		check(maskable_saved_pc, pc);
	endtask : take_mask
	task automatic take_nmi(input logic [15:0] code);
		int n;
		logic [31:0] pc;
		n = 0;
		while (!(nmi_req === 1'b1 && nmi_ack === 1'b1) && n < 40) begin
			step(1);
			n++;
		end
		pc = instr_abandonable ? current_instr_addr : following_instr_addr;
		check({30'h0, nmi_req, nmi_ack}, 32'h3);
		check({nmi_code, nmi_handler[15:0]}, {code, code});
		step(1);
		check(fatal_saved_pc, pc);
	endtask : take_nmi
	task automatic close_out;
		if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#400000;
		mismatches++;
		close_out();
	end
	initial begin
		{rst_n, nmi_pin, watchdog1_nonmask_req, watchdog2_nonmask_req, slow} = '0;
		{nonmask_active_flag, irq_disable_flag, instr_abandonable, illegal_opcode_trap} = '0;
		{src_req, src_mask, src_level, ext_edge_pin} = '0;
		{following_instr_addr, current_instr_addr} = '0;
		ce = 1'b1;
		step(6);
		rst_n = 1'b1;
		step(3);
		check({31'h0, |pending_status | mask_req | nmi_req}, 32'h0);
		// Clock enable low: a request must not land while frozen
		ce = 1'b0;
		src_req[7] = 1'b1;
		step(2);
		check({31'h0, |pending_status}, 32'h0);
		src_req = '0;
		ce = 1'b1;
		step(1);
		// Every source alone, pins through their edge inputs
		for (int s = 0; s < irq_vec_pkg::NUM_SRC; s++) begin
			rnd();
			src_level = 117'({4{seed}});
			a = (s == 34) ? 3 : s;
			if (s < 3 || s == 34) ext_edge_pin[a] = 1'b1;
			else src_req[s] = 1'b1;
			step(1);
			src_req = '0;
			take_mask(s);
			ext_edge_pin = '0;
		end
		// Simultaneous pairs: equal levels, then the later slot at a higher level
		for (int k = 0; k < 8; k++) begin
			rnd();
			a = (k == 0) ? 0 : int'(seed[15:0]) % 38;
			b = (k == 0) ? 38 : a + 1 + int'(seed[23:16]) % (38 - a);
			src_level = '0;
			if (k >= 4) src_level[a*3 +: 3] = 3'h5;
			if (k >= 4) src_level[b*3 +: 3] = 3'h1;
			src_req[a] = 1'b1;
			src_req[b] = 1'b1;
			step(1);
			src_req = '0;
			take_mask(k < 4 ? a : b);
			take_mask(k < 4 ? b : a);
		end
		// Masked, then blocked by each core flag, then accepted
		rnd();
		src_mask[5] = 1'b1;
		src_req[5] = 1'b1;
		step(1);
		src_req = '0;
		irq_disable_flag = 1'b1;
		step(6);
		check({31'h0, mask_req}, {31'h0, ~pending_status[5]});
		src_mask = '0;
		step(4);
		check({31'h0, mask_req}, 32'h0);
		irq_disable_flag = 1'b0;
		nonmask_active_flag = 1'b1;
		step(4);
		check({31'h0, mask_req}, 32'h0);
		nonmask_active_flag = 1'b0;
		take_mask(5);
		// All nonmask sources together, then the first watchdog held by the flag
		rnd();
		{watchdog1_nonmask_req, watchdog2_nonmask_req, nmi_pin} = 3'h7;
		step(1);
		{watchdog1_nonmask_req, watchdog2_nonmask_req} = 2'h0;
		take_nmi(16'h0030);
		take_nmi(16'h0020);
		take_nmi(16'h0010);
		nonmask_active_flag = 1'b1;
		watchdog1_nonmask_req = 1'b1;
		step(1);
		watchdog1_nonmask_req = 1'b0;
		step(5);
		check({31'h0, nmi_req}, 32'h0);
		watchdog2_nonmask_req = 1'b1;
		step(1);
		watchdog2_nonmask_req = 1'b0;
		take_nmi(16'h0030);
		nonmask_active_flag = 1'b0;
		take_nmi(16'h0020);
		illegal_opcode_trap = 1'b1;
		step(1);
		illegal_opcode_trap = 1'b0;
		check(illegal_instr_addr, following_instr_addr - 32'h0000_0004);
		check(debug_saved_pc, following_instr_addr);
		step(4);
		close_out();
	end
endmodule : testbench
